// ==== core/pesc_ctrl.sv ====
// pesc_ctrl: precise event sampling control, record generation and apb registers
`timescale 1ns/1ps
`default_nettype none
module pesc_ctrl
   import pesc_pkg::*;
#(
   parameter int ADDR_W = 64,              // linear address width
   parameter int LAT_W  = 16               // latency input width
) (
   input  wire logic              clk_sys,       // core clock
   input  wire logic              rst_n,         // sync reset, low active
   input  wire logic              psel,          // apb select
   input  wire logic              penable,       // apb access phase
   input  wire logic              pwrite,        // apb write
   input  wire logic [7:0]        paddr,         // apb byte address
   input  wire logic [31:0]       pwdata,        // apb write data
   output logic [31:0]            prdata,        // apb read data
   output logic                   pready,        // apb ready
   output logic                   pslverr,       // apb error, unmapped
   input  wire logic [N_CNT-1:0]  cnt_ovf,       // counter overflow pulses
   input  wire logic [N_CNT-1:0]  cnt_evt,       // counter event pulses
   input  wire logic [ADDR_W-1:0] ld_addr,       // load source linear address
   input  wire logic [3:0]        ld_src,        // load data source code
   input  wire logic              ld_stlb_miss,  // load missed stlb
   input  wire logic              ld_lock,       // load was locked
   input  wire logic [LAT_W-1:0]  ld_lat,        // load latency cycles
   input  wire logic [ADDR_W-1:0] st_addr,       // store destination address
   input  wire logic              st_dcu_hit,    // store hit l1 data cache
   input  wire logic              st_stlb_miss,  // store missed stlb
   input  wire logic              st_lock,       // store was locked
   output logic                   rec_valid,     // record ready to write
   input  wire logic              rec_ready,     // memory accepts record
   output logic [31:0]            rec_addr,      // record byte address
   output logic [1:0]             rec_cnt,       // counter that triggered
   output logic [ADDR_W-1:0]      rec_linaddr,   // record field 98h
   output logic [63:0]            rec_dsrc,      // record field a0h
   output logic [63:0]            rec_lat,       // record field a8h
   output logic                   irq            // level interrupt
);

   logic [N_SAMP-1:0]  samp_en_r, ll_en_r, armed_r;
   logic               ps_en_r, buf_full_r;
   logic [31:0]        evsel_r [N_SAMP];
   logic [N_CNT-1:0]   ovf_r;
   logic [31:0]        buf_base_r, buf_index_r, buf_limit_r, prdata_r;
   logic [INT_W-1:0]   int_stat_r, int_mask_r, int_set;
   pesc_state_t        state_r;

   function automatic logic um_ok(input logic [7:0] um, input logic [7:0] allow);
      um_ok = (um != 8'h00) && ((um & (um - 8'h01)) == 8'h00) && ((um & allow) == um);
   endfunction : um_ok

   function automatic logic evt_ok(input int idx, input logic [31:0] sel);
      logic [7:0] code;
      logic [7:0] um;
      code = sel[EVS_CODE_LSB +: 8];
      um   = sel[EVS_UMASK_LSB +: 8];
      case (code)
         EVT_RET_INST:  evt_ok = (idx == PRECISE_RETIRED_DISTRIBUTION_CNT) && (um == UM_RET_INST);
         EVT_RET_UOPS:  evt_ok = um_ok(um, UM_RET_UOPS);
         EVT_RET_BR:    evt_ok = um_ok(um, UM_RET_BR);
         EVT_MISP_BR:   evt_ok = um_ok(um, UM_MISP_BR);
         EVT_MEM_TRANS: evt_ok = (um == UM_LOAD_LAT) || (um == UM_PREC_STORE);
         EVT_MEM_UOP:   evt_ok = um_ok(um, UM_MEM_UOP);
         EVT_LD_RET:    evt_ok = um_ok(um, UM_LD_RET);
         EVT_LD_HIT:    evt_ok = um_ok(um, UM_LD_HIT);
         EVT_LD_MISC:   evt_ok = um_ok(um, UM_LD_MISC);
         default:       evt_ok = 1'b0;
      endcase
   endfunction : evt_ok

   // apb decode
   logic wr_acc, rd_setup, mapped;
   assign wr_acc   = psel && penable && pwrite;
   assign rd_setup = psel && !penable;
   assign mapped   = (paddr[1:0] == 2'b00) && (paddr <= OFS_INT_MASK);
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !mapped;
   assign prdata   = prdata_r;

   // eligibility and trigger
   logic [N_SAMP-1:0] qual, trig;
   logic [1:0]        pick;
   logic              any_trig, pick_store, bounds_ok, rec_done, full_set, skip_evt;
   logic [32:0]       rec_end;
   logic [N_CNT-1:0]  rec_clr;

   always_comb begin
      for (int i = 0; i < N_SAMP; i++) begin
         qual[i] = samp_en_r[i] && evt_ok(i, evsel_r[i]);
      end
   end
   assign trig     = armed_r & cnt_evt[N_SAMP-1:0] & qual;
   assign any_trig = (state_r == ST_IDLE) && (trig != '0);

   always_comb begin
      pick = 2'd0;
      for (int i = N_SAMP - 1; i >= 0; i--) begin
         if (trig[i]) begin
            pick = 2'(i);
         end
      end
   end

   assign pick_store = ps_en_r && (pick == 2'(STORE_CNT)) &&
                       (evsel_r[STORE_CNT][EVS_UMASK_LSB +: 8] == UM_PREC_STORE);
   assign rec_end    = {1'b0, buf_index_r} + {1'b0, REC_BYTES};
   assign bounds_ok  = (buf_index_r >= buf_base_r) && (rec_end <= {1'b0, buf_limit_r});
   assign rec_done   = (state_r == ST_EMIT) && rec_ready;
   assign rec_valid  = (state_r == ST_EMIT);
   assign rec_clr    = rec_done ? {{(N_CNT - N_SAMP){1'b0}}, ovf_r[N_SAMP-1:0] & samp_en_r}
                                : '0;

   // state machine
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (any_trig && bounds_ok) begin
                  state_r <= ST_EMIT;
               end
            end
            ST_EMIT: begin
               if (rec_ready) begin
                  state_r <= ST_IDLE;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // arm on overflow, disarm on the triggering event
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         armed_r <= '0;
      end else begin
         for (int i = 0; i < N_SAMP; i++) begin
            if (cnt_ovf[i] && qual[i]) begin
               armed_r[i] <= 1'b1;
            end else if ((any_trig && (pick == 2'(i))) || !qual[i]) begin
               armed_r[i] <= 1'b0;
            end
         end
      end
   end

   // record capture
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rec_addr    <= RST_WORD;
         rec_cnt     <= 2'd0;
         rec_linaddr <= '0;
         rec_dsrc    <= 64'h0000000000000000;
         rec_lat     <= 64'h0000000000000000;
      end else if (any_trig) begin
         rec_addr <= buf_index_r;
         rec_cnt  <= pick;
         if (pick_store) begin
            rec_linaddr <= st_addr;
            rec_dsrc    <= {58'h0, st_lock, st_stlb_miss, 3'h0, st_dcu_hit};
            rec_lat     <= 64'h0000000000000000;
         end else begin
            rec_linaddr <= ld_addr;
            if (ll_en_r[pick]) begin
               rec_dsrc <= {58'h0, ld_lock, ld_stlb_miss, ld_src};
               rec_lat  <= {{(64 - LAT_W){1'b0}}, ld_lat};
            end else begin
               rec_dsrc <= 64'h0000000000000000;
               rec_lat  <= 64'h0000000000000000;
            end
         end
      end
   end

   // buffer index advance and full flag
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         buf_index_r <= RST_WORD;
      end else if (rec_done) begin
         buf_index_r <= rec_end[31:0];
      end else if (wr_acc && paddr == OFS_BUF_INDEX) begin
         buf_index_r <= pwdata;
      end
   end

   assign full_set = rec_done && ((rec_end[31:0] + REC_BYTES) > buf_limit_r);

   // overflow status: hardware set wins over any clear
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ovf_r      <= '0;
         buf_full_r <= 1'b0;
      end else begin
         if (wr_acc && paddr == OFS_OVF_STAT) begin
            ovf_r <= (ovf_r & ~pwdata[N_CNT-1:0] & ~rec_clr) | cnt_ovf;
            buf_full_r <= (buf_full_r & ~pwdata[BUF_FULL_BIT]) | full_set;
         end else begin
            ovf_r <= (ovf_r & ~rec_clr) | cnt_ovf;
            buf_full_r <= buf_full_r | full_set;
         end
      end
   end

   // software registers
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         samp_en_r   <= '0;
         ll_en_r     <= '0;
         ps_en_r     <= 1'b0;
         buf_base_r  <= RST_WORD;
         buf_limit_r <= RST_WORD;
         int_mask_r  <= '0;
         for (int i = 0; i < N_SAMP; i++) begin
            evsel_r[i] <= RST_WORD;
         end
      end else if (wr_acc) begin
         if (paddr == OFS_SAMP_EN_LO) begin
            samp_en_r <= pwdata[N_SAMP-1:0];
         end else if (paddr == OFS_SAMP_EN_HI) begin
            ll_en_r <= pwdata[N_SAMP-1:0];
            ps_en_r <= pwdata[PS_EN_BIT];
         end else if (paddr >= OFS_EVSEL0 && paddr <= OFS_EVSEL3 && paddr[1:0] == 2'b00) begin
            evsel_r[2'(paddr[7:2] - OFS_EVSEL0[7:2])] <= pwdata;
         end else if (paddr == OFS_BUF_BASE) begin
            buf_base_r <= pwdata;
         end else if (paddr == OFS_BUF_LIMIT) begin
            buf_limit_r <= pwdata;
         end else if (paddr == OFS_INT_MASK) begin
            int_mask_r <= pwdata[INT_W-1:0];
         end
      end
   end

   // interrupt status, write one to clear, set wins
   assign skip_evt = any_trig && !bounds_ok;
   always_comb begin
      int_set = '0;
      int_set[INT_REC_BIT]  = rec_done;
      int_set[INT_FULL_BIT] = full_set;
      int_set[INT_SKIP_BIT] = skip_evt;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         int_stat_r <= '0;
      end else if (wr_acc && paddr == OFS_INT_STAT) begin
         int_stat_r <= (int_stat_r & ~pwdata[INT_W-1:0]) | int_set;
      end else begin
         int_stat_r <= int_stat_r | int_set;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= ((int_stat_r | int_set) & int_mask_r) != '0;
      end
   end

   // read data latched in the setup phase
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         prdata_r <= RST_WORD;
      end else if (rd_setup) begin
         prdata_r <= RST_WORD;
         if (paddr == OFS_SAMP_EN_LO) begin
            prdata_r[N_SAMP-1:0] <= samp_en_r;
         end else if (paddr == OFS_SAMP_EN_HI) begin
            prdata_r[N_SAMP-1:0] <= ll_en_r;
            prdata_r[PS_EN_BIT]  <= ps_en_r;
         end else if (paddr >= OFS_EVSEL0 && paddr <= OFS_EVSEL3 && paddr[1:0] == 2'b00) begin
            prdata_r <= evsel_r[2'(paddr[7:2] - OFS_EVSEL0[7:2])];
         end else if (paddr == OFS_OVF_STAT) begin
            prdata_r[N_CNT-1:0]   <= ovf_r;
            prdata_r[BUF_FULL_BIT] <= buf_full_r;
         end else if (paddr == OFS_BUF_BASE) begin
            prdata_r <= buf_base_r;
         end else if (paddr == OFS_BUF_INDEX) begin
            prdata_r <= buf_index_r;
         end else if (paddr == OFS_BUF_LIMIT) begin
            prdata_r <= buf_limit_r;
         end else if (paddr == OFS_INT_STAT) begin
            prdata_r[INT_W-1:0] <= int_stat_r;
         end else if (paddr == OFS_INT_MASK) begin
            prdata_r[INT_W-1:0] <= int_mask_r;
         end
      end
   end

   // checks
   sequence s_armed3;
      armed_r[3] && cnt_evt[3] && qual[3] && state_r == ST_IDLE && trig[2:0] == '0;
   endsequence

   a_upper_never_arm: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(rec_valid) |-> $past((cnt_evt[N_SAMP-1:0] & samp_en_r) != '0))
      else $error("record without a sampling counter event");

   a_store_only_three: assert property (@(posedge clk_sys) disable iff (!rst_n)
      any_trig && !(ps_en_r && pick == 2'(STORE_CNT)) |=> rec_linaddr == $past(ld_addr))
      else $error("store capture off counter three");

   a_store_lat_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
      any_trig && pick_store ##1 1'b1 |-> rec_lat == 64'h0 && rec_linaddr == $past(st_addr))
      else $error("store record latency not zero");

   a_ld_addr_field: assert property (@(posedge clk_sys) disable iff (!rst_n)
      any_trig && !pick_store |=> rec_linaddr == $past(ld_addr))
      else $error("load address field wrong");

   a_ld_lat_field: assert property (@(posedge clk_sys) disable iff (!rst_n)
      any_trig && !pick_store && ll_en_r[pick] |=> rec_lat[LAT_W-1:0] == $past(ld_lat))
      else $error("latency field wrong");

   a_ovf_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rec_done && samp_en_r[0] && !cnt_ovf[0] |=> !ovf_r[0])
      else $error("overflow not cleared after record");

   a_ovf_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rec_done && ovf_r[5] && !(wr_acc && paddr == OFS_OVF_STAT) |=> ovf_r[5])
      else $error("unrelated overflow cleared");

   a_arm_trigger: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_armed3 and bounds_ok |=> rec_valid && rec_cnt == 2'd3)
      else $error("armed event made no record");

   a_skip_bounds: assert property (@(posedge clk_sys) disable iff (!rst_n)
      any_trig && !bounds_ok |=> !rec_valid && int_stat_r[INT_SKIP_BIT])
      else $error("failed bounds check not skipped");

   a_full_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
      full_set |=> buf_full_r)
      else $error("buffer full not flagged");

   a_precise_retired_distribution_one: assert property (@(posedge clk_sys) disable iff (!rst_n)
      any_trig && evsel_r[pick][7:0] == EVT_RET_INST |-> pick == 2'd1)
      else $error("precise retired instructions off counter one");

   a_emit_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rec_valid && !rec_ready |=> rec_valid && $stable(rec_addr))
      else $error("record dropped before accept");

endmodule : pesc_ctrl
`default_nettype wire

// ==== core/pesc_pkg.sv ====
// pesc_pkg: constants shared by the precise event sampling controller
package pesc_pkg;
   // apb byte offsets
   localparam logic [7:0] OFS_SAMP_EN_LO = 8'h00;
   localparam logic [7:0] OFS_SAMP_EN_HI = 8'h04;
   localparam logic [7:0] OFS_EVSEL0     = 8'h08;
   localparam logic [7:0] OFS_EVSEL3     = 8'h14;
   localparam logic [7:0] OFS_OVF_STAT   = 8'h18;
   localparam logic [7:0] OFS_BUF_BASE   = 8'h1c;
   localparam logic [7:0] OFS_BUF_INDEX  = 8'h20;
   localparam logic [7:0] OFS_BUF_LIMIT  = 8'h24;
   localparam logic [7:0] OFS_INT_STAT   = 8'h28;
   localparam logic [7:0] OFS_INT_MASK   = 8'h2c;

   // sampling enable high word: load latency bits 3:0, precise store bit 31 (bit 63)
   localparam int PS_EN_BIT       = 31;
   localparam int BUF_FULL_BIT    = 31;
   localparam int N_SAMP          = 4;
   localparam int N_CNT           = 8;
   localparam int STORE_CNT       = 3;
   localparam int PRECISE_RETIRED_DISTRIBUTION_CNT        = 1;

   // event selector fields
   localparam int EVS_CODE_LSB    = 0;
   localparam int EVS_UMASK_LSB   = 8;
   localparam int EVS_EDGE_BIT    = 18;
   localparam int EVS_ANY_BIT     = 21;
   localparam int EVS_INV_BIT     = 23;
   localparam int EVS_COUNT_THRESHOLD_FIELD_LSB   = 24;

   // interrupt status bits
   localparam int INT_REC_BIT     = 0;
   localparam int INT_FULL_BIT    = 1;
   localparam int INT_SKIP_BIT    = 2;
   localparam int INT_W           = 3;

   // record layout
   localparam logic [31:0] REC_BYTES    = 32'h000000b0;
   localparam logic [7:0]  REC_LINADDR  = 8'h98;
   localparam logic [7:0]  REC_DSRC     = 8'ha0;
   localparam logic [7:0]  REC_LAT      = 8'ha8;

   // eligible event codes and allowed unit mask sets
   localparam logic [7:0] EVT_RET_INST  = 8'hc0;
   localparam logic [7:0] EVT_RET_UOPS  = 8'hc2;
   localparam logic [7:0] EVT_RET_BR    = 8'hc4;
   localparam logic [7:0] EVT_MISP_BR   = 8'hc5;
   localparam logic [7:0] EVT_MEM_TRANS = 8'hcd;
   localparam logic [7:0] EVT_MEM_UOP   = 8'hd0;
   localparam logic [7:0] EVT_LD_RET    = 8'hd1;
   localparam logic [7:0] EVT_LD_HIT    = 8'hd2;
   localparam logic [7:0] EVT_LD_MISC   = 8'hd4;
   localparam logic [7:0] UM_RET_INST   = 8'h01;
   localparam logic [7:0] UM_RET_UOPS   = 8'h03;
   localparam logic [7:0] UM_RET_BR     = 8'h7f;
   localparam logic [7:0] UM_MISP_BR    = 8'h37;
   localparam logic [7:0] UM_LOAD_LAT   = 8'h01;
   localparam logic [7:0] UM_PREC_STORE = 8'h02;
   localparam logic [7:0] UM_MEM_UOP    = 8'hf3;
   localparam logic [7:0] UM_LD_RET     = 8'h47;
   localparam logic [7:0] UM_LD_HIT     = 8'h0f;
   localparam logic [7:0] UM_LD_MISC    = 8'h02;

   localparam logic [31:0] RST_WORD     = 32'h00000000;

   typedef enum {ST_IDLE, ST_EMIT} pesc_state_t;
endpackage : pesc_pkg

// ==== verification/pesc_ctrl_test.sv ====
// pesc_ctrl_test: directed bench for the precise event sampling controller
`timescale 1ns/1ps
`default_nettype none
module pesc_ctrl_test;
   import pesc_pkg::*;
   localparam logic [63:0] LA = 64'h00007fffa5a50008;
   localparam logic [63:0] SA = 64'h00007fff5a5a0040;
   logic              clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0]        paddr, cnt_ovf, cnt_evt;
   logic [31:0]       pwdata, prdata, rec_addr, rq;
   logic              rec_valid, rec_ready, irq, re, got;
   logic [1:0]        rec_cnt;
   logic [63:0]       rec_linaddr, rec_dsrc, rec_lat, ld_addr, st_addr;
   logic [15:0]       ld_lat;
   logic [3:0]        ld_src;
   logic              ld_lock;
   int                mismatches, check_count;
   logic [16:0]       tab [10] = '{17'h102c2, 17'h101c2, 17'h140c4, 17'h120c5, 17'h101cd,
                                   17'h104d1, 17'h108d2, 17'h102d4, 17'h180d0, 17'h080c4};

   pesc_ctrl DUT (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cnt_ovf(cnt_ovf), .cnt_evt(cnt_evt), .ld_addr(ld_addr),
      .ld_src(ld_src), .ld_stlb_miss(1'b1), .ld_lock(ld_lock), .ld_lat(ld_lat), .st_addr(st_addr),
      .st_dcu_hit(1'b1), .st_stlb_miss(1'b1), .st_lock(1'b1), .rec_valid(rec_valid),
      .rec_ready(rec_ready), .rec_addr(rec_addr), .rec_cnt(rec_cnt),
      .rec_linaddr(rec_linaddr), .rec_dsrc(rec_dsrc), .rec_lat(rec_lat), .irq(irq));

   always #2.5 clk_sys = ~clk_sys;

   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : final_report

   task automatic check(input logic [63:0] g, input logic [63:0] x);
      check_count++;
      if (g !== x) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask : check

   // one apb transfer, then an idle edge so psel is never reassigned in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge clk_sys);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         check(0, 1);
         final_report();
      end
      rq = prdata; re = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk_sys);
   endtask : apb

   task automatic sample(input logic [7:0] ov, input logic [7:0] ev);
      int n;
      cnt_ovf <= ov; @(posedge clk_sys); cnt_ovf <= '0; @(posedge clk_sys);
      cnt_evt <= ev; @(posedge clk_sys); cnt_evt <= '0;
      got = 1'b0;
      for (n = 0; n < 6; n++) begin
         @(posedge clk_sys);
         if (rec_valid === 1'b1) begin
            got = 1'b1;
            break;
         end
      end
   endtask : sample

   task automatic accept();
      rec_ready <= 1'b1; @(posedge clk_sys); rec_ready <= 1'b0; @(posedge clk_sys);
   endtask : accept

   task automatic t_regs();
      apb(0, OFS_SAMP_EN_LO, 0); check(rq, 0);
      apb(1, OFS_SAMP_EN_LO, 32'hffffffff);
      apb(0, OFS_SAMP_EN_LO, 0); check(rq, 32'h0000000f);
      apb(0, 8'h30, 0); check({re, rq}, {1'b1, 32'h0});
      $display("done: registers");
   endtask : t_regs

   task automatic t_load();
      apb(1, OFS_BUF_BASE, 32'h1000); apb(1, OFS_BUF_INDEX, 32'h1000);
      apb(1, OFS_BUF_LIMIT, 32'h2000); apb(1, OFS_INT_MASK, 32'h1);
      apb(1, OFS_EVSEL0, 32'h1c2);
      apb(1, OFS_SAMP_EN_HI, 32'h1); apb(1, OFS_SAMP_EN_LO, 32'h1);
      sample(8'h25, 8'h01); check(got, 1);
      repeat (2) @(posedge clk_sys);
      check(rec_valid, 1); check(rec_addr, 32'h1000); check(rec_cnt, 0);
      check(rec_linaddr, LA);
      check(rec_dsrc, 64'h19);
      check(rec_lat, 64'h1234);
      accept();
      apb(0, OFS_OVF_STAT, 0); check(rq, 32'h24);
      apb(0, OFS_BUF_INDEX, 0); check(rq, 32'h10b0);
      check(irq, 1);
      apb(1, OFS_INT_STAT, 32'h1); @(posedge clk_sys); check(irq, 0);
      apb(1, OFS_OVF_STAT, 32'hff);
      $display("done: load record");
   endtask : t_load

   task automatic t_store();
      apb(1, OFS_EVSEL3, 32'h2cd); apb(1, OFS_SAMP_EN_HI, 32'h80000000);
      apb(1, OFS_SAMP_EN_LO, 32'h8);
      sample(8'h08, 8'h08); check(got, 1);
      check(rec_cnt, 3); check(rec_linaddr, SA);
      check(rec_dsrc, 64'h31);
      check(rec_lat, 0);
      accept();
      // store code on counter two must keep the load format
      apb(1, OFS_EVSEL0 + 8'h08, 32'h2cd); apb(1, OFS_SAMP_EN_HI, 32'h80000004);
      apb(1, OFS_SAMP_EN_LO, 32'h4);
      ld_addr <= LA + 64'h40; ld_src <= 4'h3; ld_lock <= 1'b1; ld_lat <= 16'h0042;
      sample(8'h04, 8'h04); check(got, 1);
      check(rec_linaddr, LA + 64'h40);
      check(rec_dsrc, 64'h33); check(rec_lat, 64'h42);
      accept();
      $display("done: store record");
   endtask : t_store

   task automatic t_events();
      int i;
      apb(1, OFS_SAMP_EN_HI, 0);
      apb(1, OFS_EVSEL0, 32'h1c0); apb(1, OFS_SAMP_EN_LO, 32'h1);
      sample(8'h01, 8'h01); check(got, 0);
      apb(1, OFS_EVSEL0 + 8'h04, 32'h1c0); apb(1, OFS_SAMP_EN_LO, 32'h2);
      sample(8'h02, 8'h02); check(got, 1);
      check(rec_cnt, 1); check(rec_dsrc, 0); check(rec_lat, 0);
      accept();
      apb(1, OFS_SAMP_EN_LO, 32'hf0);
      sample(8'hf0, 8'hf0); check(got, 0);
      apb(1, OFS_SAMP_EN_LO, 32'h4);
      for (i = 0; i < 10; i++) begin
         apb(1, OFS_EVSEL0 + 8'h08, {16'h0, tab[i][15:0]});
         sample(8'h04, 8'h04); check(got, tab[i][16]);
         if (got) accept();
      end
      $display("done: event table");
   endtask : t_events

   task automatic t_bounds();
      apb(1, OFS_EVSEL0 + 8'h08, 32'h1c2); apb(1, OFS_BUF_INDEX, 32'h1f50);
      sample(8'h04, 8'h04); check(got, 1); check(rec_addr, 32'h1f50);
      accept();
      apb(0, OFS_OVF_STAT, 0); check(rq[BUF_FULL_BIT], 1);
      sample(8'h04, 8'h04); check(got, 0);
      apb(0, OFS_INT_STAT, 0); check(rq[INT_SKIP_BIT], 1);
      apb(0, OFS_BUF_INDEX, 0); check(rq, 32'h2000);
      $display("done: buffer bounds");
   endtask : t_bounds

   initial begin
      clk_sys = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = '0; pwdata = '0; cnt_ovf = '0; cnt_evt = '0; rec_ready = 1'b0;
      ld_addr = LA; st_addr = SA; ld_src = 4'h9; ld_lock = 1'b0; ld_lat = 16'h1234;
      mismatches = 0; check_count = 0;
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      t_regs();
      t_load();
      t_store();
      t_events();
      t_bounds();
      final_report();
   end
endmodule : pesc_ctrl_test
`default_nettype wire
